// [hdl/sbrs_pkg.sv]
// package: register map, field positions, reset values and timing counts for the sequencer
package sbrs_pkg;
  localparam logic [15:0] SBRS_OFS_BRK_STATUS = 16'hFE00;
  localparam logic [15:0] SBRS_OFS_RST_SOURCE = 16'hFE01;
  localparam logic [15:0] SBRS_OFS_BRK_FLGCTL = 16'hFE03;
  localparam int          SBRS_BIT_EXIT_FLAG  = 1;
  localparam int          SBRS_BIT_CLR_EN     = 7;
  localparam int          SBRS_BIT_POWER_ON   = 7;
  localparam int          SBRS_BIT_PIN        = 6;
  localparam int          SBRS_BIT_WATCHDOG   = 5;
  localparam int          SBRS_BIT_BAD_OPCODE = 4;
  localparam int          SBRS_BIT_BAD_FETCH  = 3;
  localparam int          SBRS_BIT_LOW_VOLT   = 1;
  localparam logic [7:0]  SBRS_RST_SOURCE_RST = 8'h80;
  localparam logic [7:0]  SBRS_RST_SOURCE_MSK = 8'hFA;
  localparam int          SBRS_REC_LONG_CYC   = 4096;
  localparam int          SBRS_REC_SHORT_CYC  = 32;
  localparam logic [1:0]  SBRS_RESP_OKAY      = 2'h0;
  localparam logic [1:0]  SBRS_RESP_SLVERR    = 2'h2;

  // reset cause pulses from the chip, one bit per source
  typedef struct packed {
    logic power_on;
    logic pin;
    logic watchdog;
    logic bad_opcode;
    logic bad_fetch;
    logic low_volt;
  } sbrs_rst_t;

  // core status into the sequencer
  typedef struct packed {
    logic wait_exec;
    logic stop_exec;
    logic irq_pending;
    logic brk_req;
  } sbrs_core_t;

  typedef enum logic [1:0] {
    SBRS_RUN,
    SBRS_WAIT,
    SBRS_STOP,
    SBRS_RECOVER
  } sbrs_state_t;
endpackage

// [hdl/sbrs_top.sv]
// sequencer top: reset status, break handling, wait and stop sequencing, AXI4-Lite registers
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module sbrs_top
  import sbrs_pkg::*;
#(
  parameter int REC_LONG  = SBRS_REC_LONG_CYC,
  parameter int REC_SHORT = SBRS_REC_SHORT_CYC
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address and data
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // reset causes, same-clock pulses
  input  wire sbrs_rst_t   rst_cause,
  input  wire logic        fetch_cycle,
  // core side
  input  wire sbrs_core_t  core_in,
  input  wire logic        short_stop_recovery,
  input  wire logic        watchdog_disable_bit,
  // controls toward core and peripherals
  output logic             sys_reset,
  output logic             force_swi_vector,
  output logic             clear_int_mask,
  output logic             stack_start,
  output logic             core_clk_en,
  output logic             periph_clk_en,
  output logic             clock_gen_output_en,
  output logic             watchdog_enable,
  output logic             break_mode,
  output logic             flag_clear_allow
);

  // ---- state
  sbrs_state_t st_r, st_nxt;
  logic [12:0] cnt_r, cnt_nxt;
  logic [7:0]  src_r, src_nxt;
  logic        exit_flag_r, exit_flag_nxt;
  logic        clr_en_r;
  logic        brk_r;
  logic        aw_hold_r, w_hold_r;
  logic [31:0] awaddr_r, wdata_r;
  logic        wstrb0_r;

  // ---- reset priority: any cause, no arbitration among them
  // equal reset priority
  wire any_rst = |{rst_cause.power_on, rst_cause.pin, rst_cause.watchdog,
                   rst_cause.bad_opcode, rst_cause.bad_fetch, rst_cause.low_volt};

  // ---- bus decode
  wire        wr_go   = aw_hold_r && w_hold_r && !s_axi_bvalid;
  wire [15:0] wa      = awaddr_r[17:2];
  wire [15:0] ra      = s_axi_araddr[17:2];
  wire        wr_bs   = wr_go && (wa == SBRS_OFS_BRK_STATUS);
  wire        wr_fc   = wr_go && (wa == SBRS_OFS_BRK_FLGCTL);
  wire        wr_ok   = (wa == SBRS_OFS_BRK_STATUS) || (wa == SBRS_OFS_RST_SOURCE)
                        || (wa == SBRS_OFS_BRK_FLGCTL);
  wire        rd_go   = s_axi_arvalid && s_axi_arready;
  wire        rd_bs   = (ra == SBRS_OFS_BRK_STATUS);
  wire        rd_rs   = (ra == SBRS_OFS_RST_SOURCE);
  wire        rd_fc   = (ra == SBRS_OFS_BRK_FLGCTL);
  wire        rd_ok   = rd_bs || rd_rs || rd_fc;
  wire [7:0]  rd_byte = rd_bs ? {6'h00, exit_flag_r, 1'b0} :
                        rd_rs ? src_r :
                        rd_fc ? {clr_en_r, 7'h00} : 8'h00;

  // ---- recovery length and mode
  wire [12:0] rec_len = short_stop_recovery ? 13'(REC_SHORT) : 13'(REC_LONG);
  // only a halted core is woken by break; recovery is already on its way out
  wire        low_pwr = (st_r == SBRS_WAIT) || (st_r == SBRS_STOP);

  // ---- reset source register next value
  always_comb begin
    src_nxt = src_r;
    if (rd_go && rd_rs) begin
      src_nxt = 8'h00;
    end
    if (any_rst) begin
      src_nxt[SBRS_BIT_PIN]        = src_nxt[SBRS_BIT_PIN] | rst_cause.pin;
      src_nxt[SBRS_BIT_WATCHDOG]   = src_nxt[SBRS_BIT_WATCHDOG] | rst_cause.watchdog;
      src_nxt[SBRS_BIT_BAD_OPCODE] = src_nxt[SBRS_BIT_BAD_OPCODE] | rst_cause.bad_opcode;
      src_nxt[SBRS_BIT_BAD_FETCH]  = src_nxt[SBRS_BIT_BAD_FETCH]
                                     | (rst_cause.bad_fetch & fetch_cycle);
      src_nxt[SBRS_BIT_LOW_VOLT]   = src_nxt[SBRS_BIT_LOW_VOLT] | rst_cause.low_volt;
    end
    if (rst_cause.power_on) begin
      src_nxt = SBRS_RST_SOURCE_RST;
    end
    src_nxt = src_nxt & SBRS_RST_SOURCE_MSK;
  end

  // ---- break exit flag next value
  always_comb begin
    exit_flag_nxt = exit_flag_r;
    if (wr_bs && wstrb0_r && !wdata_r[SBRS_BIT_EXIT_FLAG]) begin
      exit_flag_nxt = 1'b0;
    end
    if (core_in.brk_req && low_pwr) begin
      exit_flag_nxt = 1'b1;
    end
    if (any_rst) begin
      exit_flag_nxt = 1'b0;
    end
  end

  // ---- low-power state machine
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      SBRS_RUN: begin
        if (core_in.stop_exec) begin
          st_nxt  = SBRS_STOP;
          cnt_nxt = 13'h0000;
        end else if (core_in.wait_exec) begin
          st_nxt = SBRS_WAIT;
        end
      end
      SBRS_WAIT: begin
        if (core_in.irq_pending || core_in.brk_req) begin
          st_nxt = SBRS_RUN;
        end
      end
      SBRS_STOP: begin
        cnt_nxt = 13'h0000;
        if (core_in.irq_pending || core_in.brk_req) begin
          st_nxt = SBRS_RECOVER;
        end
      end
      SBRS_RECOVER: begin
        cnt_nxt = cnt_r + 13'h0001;
        if (cnt_r == rec_len - 13'h0001) begin
          st_nxt  = SBRS_RUN;
          cnt_nxt = 13'h0000;
        end
      end
      default: st_nxt = SBRS_RUN;
    endcase
    if (any_rst) begin
      st_nxt  = SBRS_RUN;
      cnt_nxt = 13'h0000;
    end
  end

  // ---- sequencer registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r        <= SBRS_RUN;
      cnt_r       <= 13'h0000;
      src_r       <= SBRS_RST_SOURCE_RST;
      exit_flag_r <= 1'b0;
      brk_r       <= 1'b0;
    end else begin
      st_r        <= st_nxt;
      cnt_r       <= cnt_nxt;
      src_r       <= src_nxt;
      exit_flag_r <= exit_flag_nxt;
      brk_r       <= any_rst ? 1'b0 : core_in.brk_req;
    end
  end

  // ---- clear enable bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clr_en_r <= 1'b0;
    end else if (any_rst) begin
      clr_en_r <= 1'b0;
    end else if (wr_fc && wstrb0_r) begin
      clr_en_r <= wdata_r[SBRS_BIT_CLR_EN];
    end
  end

  // ---- core and peripheral controls, all registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_reset           <= 1'b1;
      force_swi_vector    <= 1'b0;
      clear_int_mask      <= 1'b0;
      stack_start         <= 1'b0;
      core_clk_en         <= 1'b1;
      periph_clk_en       <= 1'b1;
      clock_gen_output_en <= 1'b1;
      watchdog_enable     <= 1'b0;
      break_mode          <= 1'b0;
      flag_clear_allow    <= 1'b1;
    end else begin
      sys_reset           <= any_rst;
      force_swi_vector    <= core_in.brk_req && !any_rst;
      clear_int_mask      <= (core_in.wait_exec || core_in.stop_exec) && st_r == SBRS_RUN;
      stack_start         <= ((st_r == SBRS_WAIT && core_in.irq_pending)
                              || (st_r == SBRS_RECOVER && st_nxt == SBRS_RUN)) && !any_rst;
      core_clk_en         <= (st_nxt == SBRS_RUN);
      periph_clk_en       <= (st_nxt != SBRS_STOP);
      clock_gen_output_en <= (st_nxt != SBRS_STOP);
      watchdog_enable     <= !watchdog_disable_bit && (st_nxt != SBRS_STOP);
      break_mode          <= brk_r;
      flag_clear_allow    <= !brk_r || clr_en_r;
    end
  end

  // ---- axi write channel: capture address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r    <= 1'b0;
      w_hold_r     <= 1'b0;
      awaddr_r     <= 32'h0000_0000;
      wdata_r      <= 32'h0000_0000;
      wstrb0_r     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= SBRS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb0_r <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? SBRS_RESP_OKAY : SBRS_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ready while nothing is held for that channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_hold_r && !(s_axi_awvalid && s_axi_awready) && !wr_go;
      s_axi_wready  <= !w_hold_r && !(s_axi_wvalid && s_axi_wready) && !wr_go;
    end
  end

  // ---- axi read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= SBRS_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_go && !s_axi_arready;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_byte};
        s_axi_rresp  <= rd_ok ? SBRS_RESP_OKAY : SBRS_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---- check helper: cycles spent in recovery, counted apart from the design counter
  logic [12:0] rec_seen_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rec_seen_r <= 13'h0000;
    end else if (st_r == SBRS_RECOVER) begin
      rec_seen_r <= rec_seen_r + 13'h0001;
    end else begin
      rec_seen_r <= 13'h0000;
    end
  end

  // ---- checks
  // power-on sets only its flag
  por_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rst_cause.power_on |=> src_r == SBRS_RST_SOURCE_RST)
    else $error("power-on did not load reset source");
  rd_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_go && rd_rs && !any_rst) |=> src_r == 8'h00)
    else $error("reset source not cleared by read");
  // data access never sets fetch flag
  fetch_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!src_r[SBRS_BIT_BAD_FETCH] && !fetch_cycle && !rst_cause.power_on)
      |=> !src_r[SBRS_BIT_BAD_FETCH])
    else $error("fetch flag set outside a fetch");
  src_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (src_r & ~SBRS_RST_SOURCE_MSK) == 8'h00)
    else $error("reset source unused bit set");
  // break during low power sets exit flag
  brk_exit_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (core_in.brk_req && low_pwr && !any_rst) |=> exit_flag_r)
    else $error("break exit flag not set");
  exit_rst_a: assert property (@(posedge aclk) disable iff (!aresetn)
    any_rst |=> !exit_flag_r)
    else $error("exit flag survived reset");
  stop_clk_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == SBRS_RUN && core_in.stop_exec && !any_rst) |=> !clock_gen_output_en)
    else $error("clock output not stopped");
  wait_clk_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == SBRS_WAIT) |-> ##1 periph_clk_en)
    else $error("peripheral clocks stopped in wait");
  // recovery length follows the selected option
  sequence rec_end_s;
    st_r == SBRS_RECOVER && st_nxt == SBRS_RUN && !any_rst;
  endsequence
  rec_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rec_end_s |-> rec_seen_r == (short_stop_recovery ? 13'(REC_SHORT - 1)
                                                     : 13'(REC_LONG - 1)))
    else $error("recovery length wrong");
  protect_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (brk_r && !clr_en_r) |=> !flag_clear_allow)
    else $error("flags clearable in break");
  // wait or stop clears the mask
  mask_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == SBRS_RUN && (core_in.wait_exec || core_in.stop_exec)) |=> clear_int_mask)
    else $error("interrupt mask not cleared");
  cnt_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == SBRS_STOP) |-> cnt_r == 13'h0000)
    else $error("counter running in stop");
  swi_force_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (core_in.brk_req && !any_rst) |=> force_swi_vector)
    else $error("break did not force the vector");
  wait_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == SBRS_WAIT && core_in.irq_pending && !any_rst) |=> stack_start)
    else $error("no stacking after wait wake");
  stop_stack_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == SBRS_STOP) |=> !stack_start)
    else $error("stacking started inside stop");
endmodule
`default_nettype wire

// [dv/sbrs_core_model.sv]
// core and break source stand-in: turns bench commands into core status
`timescale 1ns/1ns
`default_nettype none
module sbrs_core_model
  import sbrs_pkg::*;
(
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // bench command, taken when go toggles
  input  wire logic [2:0] cmd,
  input  wire logic       go,
  // sequencer feedback and core status
  input  wire logic       stack_start,
  output sbrs_core_t      core_in
);
  logic go_r;
  logic new_cmd;

  // a fresh command shows as a toggle that differs from its copy
  assign new_cmd = go != go_r;

  // one-cycle instruction pulses, held request levels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      go_r    <= 1'b0;
      core_in <= '0;
    end else begin
      go_r              <= go;
      core_in.wait_exec <= new_cmd && cmd == 3'd1;
      core_in.stop_exec <= new_cmd && cmd == 3'd2;
      // the core drops its request once stacking starts
      if (stack_start) begin
        core_in.irq_pending <= 1'b0;
      end else if (new_cmd && cmd == 3'd3) begin
        core_in.irq_pending <= 1'b1;
      end
      if (new_cmd && cmd == 3'd4) begin
        core_in.brk_req <= 1'b1;
      end else if (new_cmd && cmd == 3'd5) begin
        core_in.brk_req <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [dv/sbrs_top_tb.sv]
// testbench: register access, reset causes, wait, stop and break sequences
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
`define WAITHI(s, lim) n = 0; \
  while ((s) !== 1'b1 && n < (lim)) begin @(posedge aclk); n++; end
module sbrs_top_tb;
  import sbrs_pkg::*;
  localparam int          RL    = 64;
  localparam int          RS    = 32;
  localparam logic [31:0] A_BS  = {14'h0, SBRS_OFS_BRK_STATUS, 2'h0};
  localparam logic [31:0] A_SRC = {14'h0, SBRS_OFS_RST_SOURCE, 2'h0};
  localparam logic [31:0] A_FC  = {14'h0, SBRS_OFS_BRK_FLGCTL, 2'h0};
  localparam logic [31:0] A_NO  = 32'h0003F808;
  localparam logic [5:0]  CZ [8] = '{6'h10, 6'h08, 6'h04, 6'h02, 6'h02, 6'h01, 6'h18, 6'h30};
  localparam logic [7:0]  EX [8] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h00, 8'h02, 8'h60, 8'h80};
  logic        aclk, aresetn = 1'b0, short_stop_recovery = 1'b0, fetch_cycle = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, go = 1'b0, wd_off = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, r;
  logic [2:0]  cmd = 3'd0;
  logic [7:0]  d;
  sbrs_rst_t   rst_cause = '0;
  sbrs_core_t  core_in;
  logic        sys_reset, force_swi_vector, clear_int_mask, stack_start, core_clk_en;
  logic        periph_clk_en, clock_gen_output_en, watchdog_enable, break_mode, flag_clear_allow;
  int          failures = 0, cmp_count = 0, n, lim;

  sbrs_top #(.REC_LONG(RL), .REC_SHORT(RS)) sbrs_top_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .rst_cause(rst_cause), .fetch_cycle(fetch_cycle), .core_in(core_in),
    .short_stop_recovery(short_stop_recovery), .watchdog_disable_bit(wd_off),
    .sys_reset(sys_reset), .force_swi_vector(force_swi_vector),
    .clear_int_mask(clear_int_mask), .stack_start(stack_start), .core_clk_en(core_clk_en),
    .periph_clk_en(periph_clk_en), .clock_gen_output_en(clock_gen_output_en),
    .watchdog_enable(watchdog_enable), .break_mode(break_mode),
    .flag_clear_allow(flag_clear_allow));

  sbrs_core_model sbrs_core_model_inst (.aclk(aclk), .aresetn(aresetn), .cmd(cmd), .go(go),
    .stack_start(stack_start), .core_in(core_in));

  // 25 MHz clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // write one register byte, both channels offered together
  task automatic wr(input logic [31:0] a, input logic [7:0] v, output logic [1:0] rs);
    logic aw_d, w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(posedge aclk);
      aw_d = aw_d | (awvalid & awready);
      w_d = w_d | (wvalid & wready);
      awvalid <= !aw_d;
      wvalid <= !w_d;
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
  endtask

  // read one register byte
  task automatic rd(input logic [31:0] a, output logic [7:0] v, output logic [1:0] rs);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    v = rdata[7:0];
    rs = rresp;
  endtask

  // hand a command to the core model
  task automatic core_cmd(input logic [2:0] c);
    cmd <= c;
    go <= !go;
    @(posedge aclk);
  endtask

  // one-cycle reset cause pulse, then settle
  task automatic cause(input logic [5:0] v, input logic f);
    rst_cause <= sbrs_rst_t'(v);
    fetch_cycle <= f;
    @(posedge aclk);
    rst_cause <= '0;
    fetch_cycle <= 1'b0;
    @(posedge aclk);
    `CHK(sys_reset, 1'b1)
    repeat (2) @(posedge aclk);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    #(40 * 30000);
    failures++;
    summarize();
  end

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    // reset values, clear on read, unmapped places
    rd(A_SRC, d, r);
    `CHK(d, SBRS_RST_SOURCE_RST)
    rd(A_SRC, d, r);
    `CHK(d, 8'h00)
    rd(A_FC, d, r);
    `CHK(d, 8'h00)
    rd(A_BS, d, r);
    `CHK(d, 8'h00)
    rd(A_NO, d, r);
    `CHK({r, d}, {SBRS_RESP_SLVERR, 8'h00})
    wr(A_NO, 8'h55, r);
    `CHK(r, SBRS_RESP_SLVERR)
    wr(A_FC, 8'hFF, r);
    rd(A_FC, d, r);
    `CHK({r, d}, {SBRS_RESP_OKAY, 8'h80})
    // every cause but power-on alone, two together, fetch qualifier, power-on with pin
    for (int i = 0; i < 8; i++) begin
      cause(CZ[i], i == 3);
      rd(A_SRC, d, r);
      `CHK(d, EX[i])
    end
    rd(A_FC, d, r);
    `CHK(d, 8'h00)
    // wait entry then interrupt wake
    core_cmd(3'd1);
    `WAITHI(clear_int_mask, 8)
    `CHK(clear_int_mask, 1'b1)
    repeat (2) @(posedge aclk);
    `CHK({core_clk_en, periph_clk_en, watchdog_enable}, 3'b011)
    wd_off <= 1'b1;
    repeat (2) @(posedge aclk);
    `CHK(watchdog_enable, 1'b0)
    wd_off <= 1'b0;
    core_cmd(3'd3);
    `WAITHI(stack_start, 8)
    `CHK({stack_start, n <= 3}, 2'b11)
    // stop with long then short recovery; long first, as crystal users keep it
    for (int s = 0; s < 2; s++) begin
      // long recovery kept for the first pass
      short_stop_recovery <= s[0];
      lim = s ? RS : RL;
      core_cmd(3'd2);
      repeat (3) @(posedge aclk);
      `CHK({core_clk_en, periph_clk_en, clock_gen_output_en}, 3'b000)
      core_cmd(3'd3);
      `WAITHI(stack_start, 5000)
      `CHK({n >= lim, n <= lim + 6}, 2'b11)
    end
    short_stop_recovery <= 1'b0;
    // break during stop, flags protected while clearing is disabled
    core_cmd(3'd2);
    core_cmd(3'd4);
    `WAITHI(force_swi_vector, 8)
    `CHK(force_swi_vector, 1'b1)
    repeat (2) @(posedge aclk);
    `CHK({break_mode, flag_clear_allow}, 2'b10)
    rd(A_BS, d, r);
    `CHK(d, 8'h02)
    wr(A_FC, 8'h80, r);
    repeat (2) @(posedge aclk);
    `CHK(flag_clear_allow, 1'b1)
    wr(A_BS, 8'hFD, r);
    rd(A_BS, d, r);
    `CHK(d, 8'h00)
    // let the stop recovery run out before the next mode change
    `WAITHI(core_clk_en, 200)
    `CHK(core_clk_en, 1'b1)
    core_cmd(3'd5);
    // break during wait, then a reset clears flag and enable
    core_cmd(3'd1);
    core_cmd(3'd4);
    repeat (4) @(posedge aclk);
    core_cmd(3'd5);
    rd(A_BS, d, r);
    `CHK(d, 8'h02)
    cause(6'h08, 1'b0);
    rd(A_BS, d, r);
    `CHK(d, 8'h00)
    rd(A_FC, d, r);
    `CHK(d, 8'h00)
    summarize();
  end
endmodule
`default_nettype wire
